// ---- logic/isp_seq_regs.svh ----
`ifndef ISP_SEQ_REGS_SVH
`define ISP_SEQ_REGS_SVH
// register byte addresses on the wishbone bus
`define ADDR_FLASH_ADDR_HIGH 6'h00
`define ADDR_FLASH_ADDR_LOW 6'h04
`define ADDR_WRITE_VALUE 6'h08
`define ADDR_READ_RESULT 6'h0c
`define ADDR_TRANSFER_COUNT 6'h10
`define ADDR_RAM_POINTER 6'h14
`define ADDR_ACCUMULATOR 6'h18
`define ADDR_CALL_KEY 6'h1c
`define ADDR_PROGRAM_TIMING 6'h20
`define ADDR_CALL 6'h24
`define ADDR_STATUS 6'h28
// entry points
`define EP_PAGE_ERASE 8'h17
`define EP_MASS_ERASE 8'h1a
`define EP_READ_BYTE 8'h11
`define EP_BLOCK_READ 8'h26
`define EP_WRITE_BYTE 8'h14
`define EP_BLOCK_WRITE 8'h23
`define MASS_CONFIRM 8'h55
`define CALL_KEY_VALUE 8'h98
`define BLOCK_WRITE_MAX 8'h10
// key stays valid for this many instruction cycles
`define KEY_WINDOW 3'h6
// status bit positions
`define ST_BUSY 0
`define ST_ISP_MODE 1
`define ST_REJECTED 2
// fifo shape
`define FIFO_WIDTH 8
`define FIFO_DEPTH 4
`endif

// ---- logic/isp_seq_pkg.sv ----
`default_nettype none
package isp_seq_pkg;
   typedef enum logic [2:0] {
      op_none,
      op_page_erase,
      op_mass_erase,
      op_read_byte,
      op_block_read,
      op_write_byte,
      op_block_write
   } op_e;
   typedef enum logic [2:0] {
      st_idle,
      st_flash_req,
      st_flash_wait,
      st_ram_req,
      st_ram_wait,
      st_done
   } state_e;
   typedef logic [7:0] byte_t;
endpackage
`default_nettype wire

// ---- logic/byte_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count;
   logic push, pop;
   assign count = wr_ptr - rd_ptr;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr[AW-1:0]];
   always_comb
   begin
      next_wr_ptr = flush ? '0 : wr_ptr + (AW+1)'(push);
      next_rd_ptr = flush ? '0 : rd_ptr + (AW+1)'(pop);
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end
   always_ff @(posedge clk)
   begin
      if (push)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule // byte_fifo
`default_nettype wire

// ---- logic/flash_isp_command_sequencer.sv ----
// Behaviour
// - a call with the key valid starts the operation named by its entry point
// - entry 0x17 erases the page at the high/low flash address
// - entry 0x1A erases all flash only when accumulator holds 0x55
// - entry 0x11 reads one flash byte into the read result register
// - entry 0x26 copies n (0..255) flash bytes to RAM at the pointer
// - entry 0x14 programs the write value byte at the flash address
// - entry 0x23 copies n (0..16) RAM bytes at the pointer into flash
// - a user mass erase leaves the device in serial programming mode
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_regs.svh"
module flash_isp_command_sequencer (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic instr_cycle,
   output logic cpu_stall,
   output logic isp_mode,
   output logic flash_req,
   output logic [2:0] flash_cmd,
   output logic [15:0] flash_addr,
   output logic [7:0] flash_wdata,
   output logic [7:0] flash_timing,
   input wire logic flash_done,
   input wire logic [7:0] flash_rdata,
   output logic ram_req,
   output logic ram_we,
   output logic [7:0] ram_addr,
   output logic [7:0] ram_wdata,
   input wire logic ram_done,
   input wire logic [7:0] ram_rdata
);
   import isp_seq_pkg::*;
   // register file and sequencer state
   byte_t addr_high, addr_low, write_value, read_result, count, ram_ptr, acc;
   byte_t timing, remaining;
   logic [2:0] key_age;
   logic key_valid, rejected;
   op_e op;
   state_e state;
   byte_t next_addr_high, next_addr_low, next_write_value, next_read_result;
   byte_t next_count, next_ram_ptr, next_acc, next_timing, next_remaining;
   logic [2:0] next_key_age;
   logic next_key_valid, next_rejected, next_isp_mode, next_cpu_stall;
   op_e next_op;
   state_e next_state;
   logic next_ack;
   logic [31:0] next_dat;
   logic next_flash_req, next_ram_req, next_ram_we;
   logic [7:0] next_ram_addr;
   // fifo between flash and ram sides
   logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
   byte_t fifo_in_data, fifo_out_data;
   logic wr_access;
   assign wr_access = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
   byte_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .reset(reset),
      .flush(fifo_flush),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );
   // block read: flash bytes enter the fifo, ram side drains it;
   // block write: ram bytes enter the fifo, flash side drains it
   always_comb
   begin
      fifo_flush = (state == st_idle);
      fifo_in_valid = 1'b0;
      fifo_in_data = flash_rdata;
      fifo_out_ready = 1'b0;
      if (op == op_block_read)
      begin
         fifo_in_valid = (state == st_flash_wait) && flash_done;
         fifo_out_ready = (state == st_ram_wait) && ram_done;
      end
      else if (op == op_block_write)
      begin
         fifo_in_valid = (state == st_ram_wait) && ram_done;
         fifo_in_data = ram_rdata;
         fifo_out_ready = (state == st_flash_wait) && flash_done;
      end
   end
   always_comb
   begin
      next_addr_high = addr_high;
      next_addr_low = addr_low;
      next_write_value = write_value;
      next_read_result = read_result;
      next_count = count;
      next_ram_ptr = ram_ptr;
      next_acc = acc;
      next_timing = timing;
      next_key_age = key_age;
      next_key_valid = key_valid;
      next_rejected = rejected;
      next_isp_mode = isp_mode;
      next_op = op;
      next_state = state;
      next_remaining = remaining;
      next_flash_req = 1'b0;
      next_ram_req = 1'b0;
      next_ram_we = ram_we;
      next_ram_addr = ram_addr;
      next_cpu_stall = cpu_stall;
      next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_dat = 32'h0;
      // key expires after its window of instruction cycles
      if (key_valid && instr_cycle)
      begin
         if (key_age == `KEY_WINDOW)
            next_key_valid = 1'b0;
         else
            next_key_age = key_age + 3'h1;
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i)
      begin
         case (wb_adr_i)
            `ADDR_FLASH_ADDR_HIGH: next_dat = {24'h0, addr_high};
            `ADDR_FLASH_ADDR_LOW: next_dat = {24'h0, addr_low};
            `ADDR_WRITE_VALUE: next_dat = {24'h0, write_value};
            `ADDR_READ_RESULT: next_dat = {24'h0, read_result};
            `ADDR_TRANSFER_COUNT: next_dat = {24'h0, count};
            `ADDR_RAM_POINTER: next_dat = {24'h0, ram_ptr};
            `ADDR_ACCUMULATOR: next_dat = {24'h0, acc};
            `ADDR_PROGRAM_TIMING: next_dat = {24'h0, timing};
            `ADDR_STATUS: next_dat = {29'h0, rejected, isp_mode, state != st_idle};
            default: next_dat = 32'h0;
         endcase
      end
      // bus writes to the registers are ignored while an operation runs; the flash address still steps
      if (wr_access && state == st_idle)
      begin
         case (wb_adr_i)
            `ADDR_FLASH_ADDR_HIGH: next_addr_high = wb_dat_i[7:0];
            `ADDR_FLASH_ADDR_LOW: next_addr_low = wb_dat_i[7:0];
            `ADDR_WRITE_VALUE: next_write_value = wb_dat_i[7:0];
            `ADDR_TRANSFER_COUNT: next_count = wb_dat_i[7:0];
            `ADDR_RAM_POINTER: next_ram_ptr = wb_dat_i[7:0];
            `ADDR_ACCUMULATOR: next_acc = wb_dat_i[7:0];
            `ADDR_PROGRAM_TIMING: next_timing = wb_dat_i[7:0];
            `ADDR_CALL_KEY:
            begin
               next_key_valid = (wb_dat_i[7:0] == `CALL_KEY_VALUE);
               next_key_age = 3'h0;
            end
            `ADDR_CALL:
            begin
               next_key_valid = 1'b0;
               next_rejected = 1'b1;
               if (key_valid)
               begin
                  next_rejected = 1'b0;
                  next_state = st_flash_req;
                  next_remaining = 8'h1;
                  next_cpu_stall = 1'b1;
                  case (wb_dat_i[7:0])
                     `EP_PAGE_ERASE: next_op = op_page_erase;
                     `EP_READ_BYTE: next_op = op_read_byte;
                     `EP_WRITE_BYTE: next_op = op_write_byte;
                     `EP_MASS_ERASE:
                     begin
                        next_op = op_mass_erase;
                        if (acc != `MASS_CONFIRM)
                        begin
                           // a refused erase must not leave its code behind for the flash side
                           next_op = op_none;
                           next_state = st_idle;
                           next_rejected = 1'b1;
                           next_cpu_stall = 1'b0;
                        end
                     end
                     `EP_BLOCK_READ:
                     begin
                        next_op = op_block_read;
                        next_remaining = count;
                     end
                     `EP_BLOCK_WRITE:
                     begin
                        next_op = op_block_write;
                        // over-long counts are clipped to one row
                        next_remaining = (count > `BLOCK_WRITE_MAX) ? `BLOCK_WRITE_MAX : count;
                        next_state = st_ram_req;
                     end
                     default:
                     begin
                        next_state = st_idle;
                        next_rejected = 1'b1;
                        next_cpu_stall = 1'b0;
                     end
                  endcase
                  if (next_remaining == 8'h0)
                  begin
                     next_state = st_done;
                  end
                  next_ram_addr = ram_ptr;
               end
            end
            default:
            begin
            end
         endcase
      end
      case (state)
         st_idle:
         begin
         end
         st_flash_req:
         begin
            // block read waits for room so the fifo never overflows
            if (op != op_block_read || fifo_in_ready)
            begin
               next_flash_req = 1'b1;
               next_state = st_flash_wait;
            end
         end
         st_flash_wait:
         begin
            if (flash_done)
            begin
               if (op == op_read_byte)
                  next_read_result = flash_rdata;
               if (op == op_mass_erase)
                  next_isp_mode = 1'b1;
               if (op == op_block_read)
                  next_state = st_ram_req;
               else if (op == op_block_write)
               begin
                  {next_addr_high, next_addr_low} = {addr_high, addr_low} + 16'h1;
                  next_remaining = remaining - 8'h1;
                  next_state = (remaining == 8'h1) ? st_done : st_ram_req;
               end
               else
                  next_state = st_done;
            end
         end
         st_ram_req:
         begin
            if (op == op_block_read || fifo_in_ready)
            begin
               next_ram_req = 1'b1;
               next_ram_we = (op == op_block_read);
               next_state = st_ram_wait;
            end
         end
         st_ram_wait:
         begin
            if (ram_done)
            begin
               next_ram_addr = ram_addr + 8'h1;
               if (op == op_block_write)
                  next_state = st_flash_req;
               else
               begin
                  {next_addr_high, next_addr_low} = {addr_high, addr_low} + 16'h1;
                  next_remaining = remaining - 8'h1;
                  next_state = (remaining == 8'h1) ? st_done : st_flash_req;
               end
            end
         end
         st_done:
         begin
            next_cpu_stall = 1'b0;
            next_op = op_none;
            next_state = st_idle;
         end
         default: next_state = st_idle;
      endcase
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         addr_high <= 8'h0;
         addr_low <= 8'h0;
         write_value <= 8'h0;
         read_result <= 8'h0;
         count <= 8'h0;
         ram_ptr <= 8'h0;
         acc <= 8'h0;
         timing <= 8'h0;
         remaining <= 8'h0;
         key_age <= 3'h0;
         key_valid <= 1'b0;
         rejected <= 1'b0;
         isp_mode <= 1'b0;
         cpu_stall <= 1'b0;
         op <= op_none;
         state <= st_idle;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         flash_req <= 1'b0;
         ram_req <= 1'b0;
         ram_we <= 1'b0;
         ram_addr <= 8'h0;
      end
      else
      begin
         addr_high <= next_addr_high;
         addr_low <= next_addr_low;
         write_value <= next_write_value;
         read_result <= next_read_result;
         count <= next_count;
         ram_ptr <= next_ram_ptr;
         acc <= next_acc;
         timing <= next_timing;
         remaining <= next_remaining;
         key_age <= next_key_age;
         key_valid <= next_key_valid;
         rejected <= next_rejected;
         isp_mode <= next_isp_mode;
         cpu_stall <= next_cpu_stall;
         op <= next_op;
         state <= next_state;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
         flash_req <= next_flash_req;
         ram_req <= next_ram_req;
         ram_we <= next_ram_we;
         ram_addr <= next_ram_addr;
      end
   end
   // flash-side outputs and ram_wdata registered from the state they describe
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         flash_cmd <= 3'h0;
         flash_addr <= 16'h0;
         flash_wdata <= 8'h0;
         flash_timing <= 8'h0;
         ram_wdata <= 8'h0;
      end
      else
      begin
         flash_cmd <= next_op;
         flash_addr <= {next_addr_high, next_addr_low};
         flash_wdata <= (op == op_block_write) ? fifo_out_data : write_value;
         flash_timing <= timing;
         ram_wdata <= fifo_out_data;
      end
   end
   chk_stall_on_op: assert property (@(posedge clk) disable iff (reset)
      (state != st_idle && state != st_done) |-> cpu_stall)
      else $error("processor not stalled during operation");
   chk_mass_confirm: assert property (@(posedge clk) disable iff (reset)
      (state == st_flash_req && op == op_mass_erase) |-> acc == `MASS_CONFIRM)
      else $error("mass erase without confirmation");
   chk_isp_mode_set: assert property (@(posedge clk) disable iff (reset)
      (state == st_flash_wait && flash_done && op == op_mass_erase) |=> isp_mode)
      else $error("mass erase did not enter isp mode");
   chk_read_result: assert property (@(posedge clk) disable iff (reset)
      (state == st_flash_wait && flash_done && op == op_read_byte)
      |=> read_result == $past(flash_rdata))
      else $error("read byte result wrong");
   chk_call_needs_key: assert property (@(posedge clk) disable iff (reset)
      (wr_access && wb_adr_i == `ADDR_CALL && state == st_idle && !key_valid)
      |=> state == st_idle && !cpu_stall && rejected)
      else $error("operation started without valid key");
   chk_block_write_max: assert property (@(posedge clk) disable iff (reset)
      (op == op_block_write) |-> remaining <= `BLOCK_WRITE_MAX)
      else $error("block write longer than sixteen");
   chk_done_releases: assert property (@(posedge clk) disable iff (reset)
      (state == st_done) |=> !cpu_stall && state == st_idle)
      else $error("stall not released after completion");
   chk_block_read_ram: assert property (@(posedge clk) disable iff (reset)
      (ram_req && op == op_block_read) |-> ram_we)
      else $error("block read ram access not a write");
endmodule // flash_isp_command_sequencer
`default_nettype wire

// ---- tb/flash_ram_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_ram_model #(
   parameter int LAT = 4,
   parameter int PAGE = 64
) (
   input wire logic clk,
   input wire logic flash_req,
   input wire logic [2:0] flash_cmd,
   input wire logic [15:0] flash_addr,
   input wire logic [7:0] flash_wdata,
   output logic flash_done,
   output logic [7:0] flash_rdata,
   input wire logic ram_req,
   input wire logic ram_we,
   input wire logic [7:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   output logic ram_done,
   output logic [7:0] ram_rdata
);
   logic [7:0] flash [0:65535];
   logic [7:0] ram [0:255];
   logic [7:0] frd = 8'h00;
   logic [7:0] rrd = 8'h00;
   int fcnt = 0;
   int rcnt = 0;
   initial flash_done = 1'b0;
   initial ram_done = 1'b0;
   initial foreach (flash[i]) flash[i] = 8'hff;
   // outside its done pulse the data bus shows no stale byte
   assign flash_rdata = flash_done ? frd : ~frd;
   assign ram_rdata = ram_done ? rrd : ~rrd;
   always @(posedge clk)
   begin
      flash_done <= 1'b0;
      if (fcnt == 1)
      begin
         flash_done <= 1'b1;
         case (flash_cmd)
            3'h1: for (int i = 0; i < PAGE; i++) flash[(flash_addr & ~(PAGE - 1)) + i] = 8'hff;
            3'h2: foreach (flash[i]) flash[i] = 8'hff;
            3'h5, 3'h6: flash[flash_addr] = flash_wdata;
            default: frd <= flash[flash_addr];
         endcase
      end
      if (fcnt != 0)
         fcnt <= fcnt - 1;
      else if (flash_req)
         fcnt <= LAT;
   end
   always @(posedge clk)
   begin
      ram_done <= 1'b0;
      if (rcnt == 1)
      begin
         ram_done <= 1'b1;
         if (ram_we)
            ram[ram_addr] = ram_wdata;
         else
            rrd <= ram[ram_addr];
      end
      if (rcnt != 0)
         rcnt <= rcnt - 1;
      else if (ram_req)
         rcnt <= LAT;
   end
endmodule // flash_ram_model
`default_nettype wire

// ---- tb/flash_isp_command_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "isp_seq_regs.svh"
module flash_isp_command_sequencer_tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [5:0] adr = 6'h00;
   logic [31:0] dat = 32'h0;
   logic we = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic instr_cycle = 1'b0;
   logic [31:0] dat_o;
   logic ack, cpu_stall, isp_mode, flash_req, flash_done, ram_req, ram_we, ram_done;
   logic [2:0] flash_cmd;
   logic [15:0] flash_addr;
   logic [7:0] flash_wdata, flash_timing, flash_rdata, ram_addr, ram_wdata, ram_rdata;
   logic [31:0] q;
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   always #5 clk = ~clk;
   flash_isp_command_sequencer i_flash_isp_command_sequencer (.clk(clk), .reset(reset),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(4'hf),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .instr_cycle(instr_cycle),
      .cpu_stall(cpu_stall), .isp_mode(isp_mode), .flash_req(flash_req),
      .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_timing(flash_timing), .flash_done(flash_done), .flash_rdata(flash_rdata),
      .ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
      .ram_done(ram_done), .ram_rdata(ram_rdata));
   flash_ram_model i_flash_ram_model (.clk(clk), .flash_req(flash_req),
      .flash_cmd(flash_cmd), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
      .flash_done(flash_done), .flash_rdata(flash_rdata), .ram_req(ram_req),
      .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_done(ram_done),
      .ram_rdata(ram_rdata));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      // only the bench timeout ends a wait for the answer
      do
      begin
         @(posedge clk);
      end
      while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // key, then call; stall is looked at while the op must still run
   task automatic call(input logic [7:0] ep, input logic key, input logic busy);
      if (key)
         wb(1'b1, `ADDR_CALL_KEY, `CALL_KEY_VALUE);
      wb(1'b1, `ADDR_CALL, ep);
      repeat (3) @(posedge clk);
      check({31'h0, cpu_stall}, {31'h0, busy});
      while (cpu_stall !== 1'b0)
      begin
         @(posedge clk);
      end
   endtask
   task automatic set_addr(input logic [15:0] a);
      wb(1'b1, `ADDR_FLASH_ADDR_HIGH, a[15:8]);
      wb(1'b1, `ADDR_FLASH_ADDR_LOW, a[7:0]);
   endtask
   task automatic s_byte_ops();
      wb(1'b1, `ADDR_PROGRAM_TIMING, 8'h3c);
      set_addr(16'h1234);
      wb(1'b1, `ADDR_WRITE_VALUE, 8'ha5);
      call(`EP_WRITE_BYTE, 1'b1, 1'b1);
      check(i_flash_ram_model.flash[16'h1234], 32'ha5);
      check({24'h0, flash_timing}, 32'h3c);
      set_addr(16'h1234);
      call(`EP_READ_BYTE, 1'b1, 1'b1);
      wb(1'b0, `ADDR_READ_RESULT, 8'h00);
      check(q, 32'ha5);
      wb(1'b0, 6'h3c, 8'h00);
      check(q, 32'h0);
   endtask
   task automatic s_blocks();
      for (int i = 0; i < 16; i++) i_flash_ram_model.ram[8'h20 + i] = 8'h40 + 8'(i);
      // sixteen bytes from 0x0130 end on 0x013f, inside one 64 byte region
      set_addr(16'h0130);
      wb(1'b1, `ADDR_TRANSFER_COUNT, 8'h10);
      wb(1'b1, `ADDR_RAM_POINTER, 8'h20);
      call(`EP_BLOCK_WRITE, 1'b1, 1'b1);
      for (int i = 0; i < 16; i++) check(i_flash_ram_model.flash[16'h0130 + i], 32'h40 + i);
      check(i_flash_ram_model.flash[16'h0140], 32'hff);
      set_addr(16'h012e);
      wb(1'b1, `ADDR_TRANSFER_COUNT, 8'h12);
      wb(1'b1, `ADDR_RAM_POINTER, 8'h80);
      call(`EP_BLOCK_READ, 1'b1, 1'b1);
      for (int i = 2; i < 18; i++) check(i_flash_ram_model.ram[8'h80 + i], 32'h3e + i);
      check(i_flash_ram_model.ram[8'h80], 32'hff);
      // an empty block write finishes at once and touches nothing
      wb(1'b1, `ADDR_TRANSFER_COUNT, 8'h00);
      call(`EP_BLOCK_WRITE, 1'b1, 1'b0);
      check(i_flash_ram_model.flash[16'h0140], 32'hff);
   endtask
   task automatic s_page_erase();
      set_addr(16'h0130);
      call(`EP_PAGE_ERASE, 1'b1, 1'b1);
      check(i_flash_ram_model.flash[16'h0135], 32'hff);
      check(i_flash_ram_model.flash[16'h1234], 32'ha5);
   endtask
   task automatic s_key_expired();
      // six instruction cycles leave the key armed, a seventh expires it
      for (int k = 6; k < 8; k++)
      begin
         wb(1'b1, `ADDR_CALL_KEY, `CALL_KEY_VALUE);
         repeat (k)
         begin
            @(posedge clk);
            instr_cycle <= 1'b1;
            @(posedge clk);
            instr_cycle <= 1'b0;
         end
         set_addr(16'h1234);
         call(`EP_READ_BYTE, 1'b0, k == 6);
         wb(1'b0, `ADDR_STATUS, 8'h00);
         check(q & 32'h4, (k == 7) ? 32'h4 : 32'h0);
      end
      // an unknown entry point is refused even with a valid key
      call(8'h00, 1'b1, 1'b0);
      wb(1'b0, `ADDR_STATUS, 8'h00);
      check(q & 32'h4, 32'h4);
   endtask
   task automatic s_mass_erase();
      wb(1'b1, `ADDR_ACCUMULATOR, 8'h54);
      call(`EP_MASS_ERASE, 1'b1, 1'b0);
      check(i_flash_ram_model.flash[16'h1234], 32'ha5);
      check({31'h0, isp_mode}, 32'h0);
      wb(1'b1, `ADDR_ACCUMULATOR, `MASS_CONFIRM);
      call(`EP_MASS_ERASE, 1'b1, 1'b1);
      check(i_flash_ram_model.flash[16'h1234], 32'hff);
      check({31'h0, isp_mode}, 32'h1);
      wb(1'b0, `ADDR_STATUS, 8'h00);
      check(q & 32'h3, 32'h2);
   endtask
   always @(posedge clk)
   begin
      cycles++;
      // whole sequence needs well under a thousand cycles
      if (cycles == 40000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      s_byte_ops();
      s_blocks();
      s_page_erase();
      s_key_expired();
      s_mass_erase();
      give_verdict();
   end
endmodule // flash_isp_command_sequencer_tb
`default_nettype wire
